// ### bench/axi_lite_master.sv
`timescale 1ns/1ns
// ==========
// on-chip or debugger bus master
// ==========
module axi_lite_master (
  input  wire logic        aclk,
  output logic [11:0]      s_axi_awaddr,
  output logic [2:0]       s_axi_awprot,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic             aw_from_debugger,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [11:0]      s_axi_araddr,
  output logic [2:0]       s_axi_arprot,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic             ar_from_debugger,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  logic hung;

  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, aw_from_debugger, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, ar_from_debugger} = '0;
    s_axi_rready = 1'b0;
    hung = 1'b0;
  end

  // readies are looked at mid-cycle, where they are settled for the coming edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic dbg,
                    output logic [1:0] resp);
    logic pa, pw, ta, tw;
    int n;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    aw_from_debugger <= dbg;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while ((pa || pw) && n < 100) begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      n++;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do begin
      @(negedge aclk);
      n++;
    end while (!s_axi_bvalid && n < 100);
    resp = s_axi_bresp;
    hung = hung | (n >= 100);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic dbg, output logic [31:0] data, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    ar_from_debugger <= dbg;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      n++;
    end while (!s_axi_arready && n < 100);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 100);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    hung = hung | (n >= 100);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ### bench/debug_claim_lock_regs_sva.sv
`timescale 1ns/1ns
// ==========
// checker
// ==========
module debug_claim_lock_regs_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        aw_from_debugger,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        ar_from_debugger,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        software_lock_state
);
  logic [11:0] w_addr;
  logic [11:0] r_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_dbg;
  logic        r_dbg;
  logic        key_wr;
  logic        good_key;

  // last accepted request, so each answer can be judged against it
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      w_addr <= s_axi_awaddr;
      w_dbg  <= aw_from_debugger;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      r_addr <= s_axi_araddr;
      r_dbg  <= ar_from_debugger;
    end
  end

  assign key_wr   = w_addr == claim_lock_pkg::LOCK_KEY_ACCESS_OFF;
  assign good_key = w_data == claim_lock_pkg::UNLOCK_KEY && w_strb == 4'hF;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_itc_zero: assert property (
    s_axi_rvalid && r_addr == claim_lock_pkg::INTEGRATION_MODE_CONTROL_OFF |-> s_axi_rdata == 32'h0)
    else $error("integration control read not zero");
  a_set_impl: assert property (
    s_axi_rvalid && r_addr == claim_lock_pkg::CLAIM_TAG_SET_OFF |-> s_axi_rdata == 32'hF)
    else $error("claim set read not implemented mask");
  a_clr_rsvd: assert property (
    s_axi_rvalid && r_addr == claim_lock_pkg::CLAIM_TAG_CLEAR_OFF |-> s_axi_rdata[31:4] == 28'h0)
    else $error("claim clear reserved bits set");
  a_rep_shape: assert property (
    s_axi_rvalid && r_addr == claim_lock_pkg::LOCK_STATE_REPORT_OFF |->
    s_axi_rdata[31:2] == 30'h0 && s_axi_rdata[0] == !r_dbg && (!r_dbg || !s_axi_rdata[1]))
    else $error("lock report layout wrong");
  a_key_unlock: assert property (
    $rose(s_axi_bvalid) && key_wr && !w_dbg && good_key |-> ##[0:2] !software_lock_state)
    else $error("key write did not unlock");
  a_key_relock: assert property (
    $rose(s_axi_bvalid) && key_wr && !w_dbg && !good_key |-> ##[0:2] software_lock_state)
    else $error("wrong key did not lock");
  a_dbg_nolock: assert property (
    $rose(s_axi_bvalid) && w_dbg |-> $stable(software_lock_state)[*3])
    else $error("debugger write moved lock");
  a_lock_cause: assert property (
    !$stable(software_lock_state) |-> key_wr && !w_dbg)
    else $error("lock changed without on-chip key write");

  c_unlock: cover property ($fell(software_lock_state));
  c_dbg_wr: cover property ($rose(s_axi_bvalid) && w_dbg);
  c_clr_rd: cover property (s_axi_rvalid && r_addr == claim_lock_pkg::CLAIM_TAG_CLEAR_OFF && s_axi_rdata[2]);
endmodule

bind debug_claim_lock_regs debug_claim_lock_regs_sva u_sva (
  .aclk                (aclk),
  .aresetn             (aresetn),
  .s_axi_awaddr        (s_axi_awaddr),
  .s_axi_awvalid       (s_axi_awvalid),
  .s_axi_awready       (s_axi_awready),
  .aw_from_debugger    (aw_from_debugger),
  .s_axi_wdata         (s_axi_wdata),
  .s_axi_wstrb         (s_axi_wstrb),
  .s_axi_wvalid        (s_axi_wvalid),
  .s_axi_wready        (s_axi_wready),
  .s_axi_bvalid        (s_axi_bvalid),
  .s_axi_araddr        (s_axi_araddr),
  .s_axi_arvalid       (s_axi_arvalid),
  .s_axi_arready       (s_axi_arready),
  .ar_from_debugger    (ar_from_debugger),
  .s_axi_rdata         (s_axi_rdata),
  .s_axi_rvalid        (s_axi_rvalid),
  .software_lock_state (software_lock_state)
);

// ### bench/debug_claim_lock_regs_tb.sv
`timescale 1ns/1ns
// ==========
// register bank bench
// ==========
module debug_claim_lock_regs_tb;
  localparam logic [11:0] itc_a = claim_lock_pkg::INTEGRATION_MODE_CONTROL_OFF;
  localparam logic [11:0] set_a = claim_lock_pkg::CLAIM_TAG_SET_OFF;
  localparam logic [11:0] clr_a = claim_lock_pkg::CLAIM_TAG_CLEAR_OFF;
  localparam logic [11:0] key_a = claim_lock_pkg::LOCK_KEY_ACCESS_OFF;
  localparam logic [11:0] rep_a = claim_lock_pkg::LOCK_STATE_REPORT_OFF;
  localparam logic [31:0] key   = claim_lock_pkg::UNLOCK_KEY;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, aw_from_debugger, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, ar_from_debugger;
  logic        s_axi_rvalid, s_axi_rready, software_lock_state;
  int          miscompares, tests_run;

  debug_claim_lock_regs u_dut (.*);
  axi_lite_master u_master (.*);

  always #5 aclk = ~aclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic guard();
    if (u_master.hung) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic dbg,
                    input logic [1:0] er);
    logic [1:0] resp;
    u_master.wr(a, d, s, dbg, resp);
    guard();
    check({30'h0, resp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic dbg, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] data;
    logic [1:0]  resp;
    u_master.rd(a, dbg, data, resp);
    guard();
    check(data, exp);
    check({30'h0, resp}, {30'h0, er});
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(rep_a, 1'b0, 32'h3, 2'h0);
    rd(rep_a, 1'b1, 32'h0, 2'h0);
    rd(itc_a, 1'b0, 32'h0, 2'h0);
    rd(set_a, 1'b0, 32'hF, 2'h0);
    wr(set_a, 32'hF, 4'hF, 1'b0, 2'h0);
    rd(clr_a, 1'b0, 32'h0, 2'h0);
    wr(key_a, key, 4'h7, 1'b0, 2'h0);
    wr(key_a, key, 4'hF, 1'b1, 2'h0);
    check({31'h0, software_lock_state}, 32'h1);
    rd(rep_a, 1'b0, 32'h3, 2'h0);
    // software unlocks before touching the tag
    wr(key_a, key, 4'hF, 1'b0, 2'h0);
    check({31'h0, software_lock_state}, 32'h0);
    rd(rep_a, 1'b0, 32'h1, 2'h0);
    wr(itc_a, 32'h1, 4'hF, 1'b0, 2'h0);
    rd(itc_a, 1'b0, 32'h0, 2'h0);
    wr(set_a, 32'hFFFF_FFF5, 4'hF, 1'b0, 2'h0);
    rd(clr_a, 1'b0, 32'h5, 2'h0);
    wr(set_a, 32'h2, 4'hF, 1'b0, 2'h0);
    wr(clr_a, 32'h3, 4'hF, 1'b0, 2'h0);
    rd(clr_a, 1'b0, 32'h4, 2'h0);
    // without the byte lane 0 strobe a claim write changes nothing
    wr(set_a, 32'h8, 4'hE, 1'b0, 2'h0);
    rd(clr_a, 1'b0, 32'h4, 2'h0);
    rd(set_a, 1'b0, 32'hF, 2'h0);
    wr(key_a, 32'h0, 4'hF, 1'b1, 2'h0);
    rd(rep_a, 1'b0, 32'h1, 2'h0);
    wr(key_a, 32'h0, 4'hF, 1'b0, 2'h0);
    check({31'h0, software_lock_state}, 32'h1);
    wr(clr_a, 32'hF, 4'hF, 1'b0, 2'h0);
    wr(set_a, 32'h1, 4'hF, 1'b1, 2'h0);
    rd(clr_a, 1'b1, 32'h5, 2'h0);
    wr(12'hFFC, 32'h1, 4'hF, 1'b1, claim_lock_pkg::RESP_SLVERR);
    rd(12'hFFC, 1'b0, 32'h0, claim_lock_pkg::RESP_SLVERR);
    rd(key_a, 1'b0, 32'h0, 2'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(rep_a, 1'b0, 32'h3, 2'h0);
    check({31'h0, software_lock_state}, 32'h1);
    rd(clr_a, 1'b0, 32'h0, 2'h0);
    final_report();
  end
endmodule

// ### src/claim_lock_pkg.sv
// What this block does
// [R1] integration control register always reads zero
// [R2] bit 0 is integration mode enable
// [R3] claim-set read shows implemented tag bits
// [R4] claim-set write of one sets tag bit
// [R5] claim-clear read returns current tag value
// [R6] claim-clear write of one clears tag bit
// [R7] claim tag affects nothing, storage only
// [R8] exact 32-bit key write clears lock
// [R9] any other lock write sets lock
// [R10] lock gates writes from on-chip masters only
// [R11] debugger accesses ignore lock entirely
// [R12] locked: deny writes except lock register
// [R13] lock status bit 1 shows lock
// [R14] reserved bits read zero, writes ignored
// [R15] software unlocks before writing locked registers
package claim_lock_pkg;

  // ==========================================================
  // register map (byte addresses)
  // ==========================================================
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] INTEGRATION_MODE_CONTROL_OFF = 12'hF00;
  localparam logic [ADDR_W-1:0] CLAIM_TAG_SET_OFF            = 12'hFA0;
  localparam logic [ADDR_W-1:0] CLAIM_TAG_CLEAR_OFF          = 12'hFA4;
  localparam logic [ADDR_W-1:0] LOCK_KEY_ACCESS_OFF          = 12'hFB0;
  localparam logic [ADDR_W-1:0] LOCK_STATE_REPORT_OFF        = 12'hFB4;

  // ==========================================================
  // fields and values
  // ==========================================================
  localparam int unsigned CLAIM_BITS      = 4;
  localparam int unsigned IME_POS         = 0;
  localparam int unsigned LOCK_IMPL_POS   = 0;
  localparam int unsigned LOCK_STATE_POS  = 1;
  localparam int unsigned LOCK_SIZE_POS   = 2;
  localparam logic [31:0] UNLOCK_KEY      = 32'hC5ACCE55;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;
  localparam logic [3:0]  FULL_STROBE     = 4'hF;
  localparam logic        LOCK_RESET      = 1'h1;
  localparam logic [CLAIM_BITS-1:0] CLAIM_RESET = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_NONE    = 3'h0,
    REG_INTEGRATION_MODE_CONTROL  = 3'h1,
    REG_CSET    = 3'h2,
    REG_CCLR    = 3'h3,
    REG_KEY     = 3'h4,
    REG_LSTATE  = 3'h5
  } reg_sel_type;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'h1,
    WR_RESPOND = 2'h2
  } wr_state_type;

endpackage

// ### src/claim_tag_if.sv
`timescale 1ns/1ns
interface claim_tag_if #(
  parameter int unsigned BITS = 4
);
  logic [BITS-1:0] set_mask;
  logic [BITS-1:0] clear_mask;
  logic [BITS-1:0] tag;

  modport owner (input set_mask, input clear_mask, output tag);
  modport user  (output set_mask, output clear_mask, input tag);
endinterface

// ### src/claim_tag_store.sv
`timescale 1ns/1ns
module claim_tag_store #(
  parameter int unsigned BITS = 4
) (
  input  wire logic     aclk,
  input  wire logic     aresetn,
  claim_tag_if.owner    tags
);

  // the reset value is a package constant of the full tag width
  if (BITS < 1 || BITS > claim_lock_pkg::CLAIM_BITS) begin : g_bad_bits
    $error("claim tag width out of range");
  end

  // ==========================================================
  // one flop per tag bit, set and clear never overlap
  // ==========================================================
  genvar i;
  generate
    for (i = 0; i < BITS; i++) begin : g_bit
      logic held;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          held <= claim_lock_pkg::CLAIM_RESET[i];
        end else if (tags.set_mask[i]) begin
          held <= 1'b1; // [R4]
        end else if (tags.clear_mask[i]) begin
          held <= 1'b0; // [R6]
        end
      end
      assign tags.tag[i] = held;
    end
  endgenerate

endmodule

// ### src/debug_claim_lock_regs.sv
`timescale 1ns/1ns
module debug_claim_lock_regs #(
  parameter int unsigned CLAIM_BITS = claim_lock_pkg::CLAIM_BITS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic        aw_from_debugger,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic        ar_from_debugger,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             software_lock_state
);

  // ==========================================================
  // elaboration checks
  // ==========================================================
  // the tag occupies one fixed field of the claim registers
  if (CLAIM_BITS != claim_lock_pkg::CLAIM_BITS) begin : g_bad_claim_bits
    $error("claim tag width is fixed by the register layout");
  end
  // claim writes are qualified by the strobe of byte lane 0 only
  if (CLAIM_BITS > 8) begin : g_bad_claim_lane
    $error("claim tag must fit in byte lane 0");
  end

  // ==========================================================
  // address decode, shared by the read and write paths
  // ==========================================================
  function automatic claim_lock_pkg::reg_sel_type decode(
    input logic [claim_lock_pkg::ADDR_W-1:0] addr
  );
    claim_lock_pkg::reg_sel_type sel;
    sel = claim_lock_pkg::REG_NONE;
    case (addr)
      claim_lock_pkg::INTEGRATION_MODE_CONTROL_OFF: begin
        sel = claim_lock_pkg::REG_INTEGRATION_MODE_CONTROL;
      end
      claim_lock_pkg::CLAIM_TAG_SET_OFF: begin
        sel = claim_lock_pkg::REG_CSET;
      end
      claim_lock_pkg::CLAIM_TAG_CLEAR_OFF: begin
        sel = claim_lock_pkg::REG_CCLR;
      end
      claim_lock_pkg::LOCK_KEY_ACCESS_OFF: begin
        sel = claim_lock_pkg::REG_KEY;
      end
      claim_lock_pkg::LOCK_STATE_REPORT_OFF: begin
        sel = claim_lock_pkg::REG_LSTATE;
      end
      default: begin
        sel = claim_lock_pkg::REG_NONE;
      end
    endcase
    return sel;
  endfunction

  // ==========================================================
  // claim tag storage
  // ==========================================================
  claim_tag_if #(.BITS(CLAIM_BITS)) tags ();

  claim_tag_store #(
    .BITS    (CLAIM_BITS)
  ) u_claim_tag_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tags    (tags)
  );

  // ==========================================================
  // write channel capture
  // ==========================================================
  // address and data are taken independently, in either order,
  // and held until the response has been accepted
  claim_lock_pkg::wr_state_type wr_state;
  logic        aw_held;
  logic [11:0] aw_addr;
  logic        aw_debug;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_done;

  assign s_axi_awready = !aw_held && (wr_state == claim_lock_pkg::WR_COLLECT);
  assign s_axi_wready  = !w_held && (wr_state == claim_lock_pkg::WR_COLLECT);
  assign wr_done       = (wr_state == claim_lock_pkg::WR_RESPOND) && s_axi_bready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
    end else if (wr_done) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr  <= '0;
      aw_debug <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr  <= s_axi_awaddr;
      aw_debug <= aw_from_debugger;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
    end else if (wr_done) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data <= claim_lock_pkg::READ_ZERO;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  // ==========================================================
  // write decode and lock gating
  // ==========================================================
  claim_lock_pkg::reg_sel_type wr_sel;
  logic wr_fire;
  logic wr_allowed;
  logic wr_lane0;
  logic wr_full;
  logic key_write;

  assign wr_sel   = decode(aw_addr);
  assign wr_fire  = aw_held && w_held && (wr_state == claim_lock_pkg::WR_COLLECT);
  assign wr_lane0 = w_strb[0];
  assign wr_full  = (w_strb == claim_lock_pkg::FULL_STROBE);
  // only on-chip writes reach the lock; debugger writes to the
  // key register are answered but change nothing
  assign key_write = wr_fire && !aw_debug && (wr_sel == claim_lock_pkg::REG_KEY); // [R10] [R11]

  // the debugger path bypasses the lock; on-chip writes other
  // than to the key register are dropped while locked
  always_comb begin
    if (aw_debug) begin
      wr_allowed = 1'b1; // [R11]
    end else if (wr_sel == claim_lock_pkg::REG_KEY) begin
      wr_allowed = 1'b1;
    end else begin
      wr_allowed = !software_lock_state; // [R10] [R12]
    end
  end

  // ==========================================================
  // write response state
  // ==========================================================
  claim_lock_pkg::wr_state_type next_wr_state;
  logic [1:0]                   next_bresp;

  always_comb begin
    if (wr_sel == claim_lock_pkg::REG_NONE) begin
      next_bresp = claim_lock_pkg::RESP_SLVERR;
    end else begin
      next_bresp = claim_lock_pkg::RESP_OKAY;
    end
  end

  // the answer stays in the respond state until bready, so a
  // master that stalls its bready never loses the response
  always_comb begin
    next_wr_state = wr_state;
    case (wr_state)
      claim_lock_pkg::WR_COLLECT: begin
        if (wr_fire) begin
          next_wr_state = claim_lock_pkg::WR_RESPOND;
        end
      end
      claim_lock_pkg::WR_RESPOND: begin
        if (s_axi_bready) begin
          next_wr_state = claim_lock_pkg::WR_COLLECT;
        end
      end
      default: begin
        next_wr_state = claim_lock_pkg::WR_COLLECT;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= claim_lock_pkg::WR_COLLECT;
    end else begin
      wr_state <= next_wr_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= claim_lock_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bresp <= next_bresp;
    end
  end

  assign s_axi_bvalid = (wr_state == claim_lock_pkg::WR_RESPOND);

  // ==========================================================
  // register side effects of a write
  // ==========================================================
  // claim bits sit in byte lane 0; other lanes hold only
  // reserved bits, so their strobes change nothing
  always_comb begin
    tags.set_mask   = '0;
    tags.clear_mask = '0;
    if (wr_fire && wr_allowed && wr_lane0) begin
      if (wr_sel == claim_lock_pkg::REG_CSET) begin
        tags.set_mask = w_data[CLAIM_BITS-1:0]; // [R4] [R14]
      end
      if (wr_sel == claim_lock_pkg::REG_CCLR) begin
        tags.clear_mask = w_data[CLAIM_BITS-1:0]; // [R6] [R14]
      end
    end
  end

  // a debugger write to the key register has no effect on the lock;
  // a partial-width write can never carry the whole key
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      software_lock_state <= claim_lock_pkg::LOCK_RESET;
    end else if (key_write) begin
      if (wr_full && w_data == claim_lock_pkg::UNLOCK_KEY) begin
        software_lock_state <= 1'b0; // [R8]
      end else begin
        software_lock_state <= 1'b1; // [R9]
      end
    end
  end

  // integration mode enable is accepted but not stored: nothing
  // here has integration behaviour, so the register reads zero
  logic unused_ime;
  assign unused_ime = w_data[claim_lock_pkg::IME_POS]; // [R2]

  // ==========================================================
  // read path
  // ==========================================================
  // the debugger sees no lock at all, so the report reads zero there
  function automatic logic [31:0] lock_report_word(
    input logic locked,
    input logic from_debugger
  );
    logic [31:0] word;
    word = claim_lock_pkg::READ_ZERO;
    if (!from_debugger) begin // [R11]
      word[claim_lock_pkg::LOCK_IMPL_POS]  = 1'b1;
      word[claim_lock_pkg::LOCK_STATE_POS] = locked; // [R13]
      word[claim_lock_pkg::LOCK_SIZE_POS]  = 1'b0;
    end
    return word;
  endfunction

  claim_lock_pkg::reg_sel_type rd_sel;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  assign rd_sel = decode(s_axi_araddr);

  always_comb begin
    next_rdata = claim_lock_pkg::READ_ZERO;
    next_rresp = claim_lock_pkg::RESP_OKAY;
    case (rd_sel)
      claim_lock_pkg::REG_INTEGRATION_MODE_CONTROL: begin
        next_rdata = claim_lock_pkg::READ_ZERO; // [R1] [R2]
      end
      claim_lock_pkg::REG_CSET: begin
        next_rdata[CLAIM_BITS-1:0] = '1; // [R3] [R14]
      end
      claim_lock_pkg::REG_CCLR: begin
        next_rdata[CLAIM_BITS-1:0] = tags.tag; // [R5] [R14]
      end
      claim_lock_pkg::REG_KEY: begin
        next_rdata = claim_lock_pkg::READ_ZERO;
      end
      claim_lock_pkg::REG_LSTATE: begin
        next_rdata = lock_report_word(software_lock_state, ar_from_debugger); // [R11] [R13]
      end
      default: begin
        next_rresp = claim_lock_pkg::RESP_SLVERR;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // read data are captured with the address, so a later write
  // cannot change a word that is already waiting for rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= claim_lock_pkg::READ_ZERO;
      s_axi_rresp <= claim_lock_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ==========================================================
  // protection bits are carried but unused
  // ==========================================================
  // the tag value feeds only the read path, never any control
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot}; // [R7]

endmodule
